// ===== rtl/sensor_pkg.sv
// constants, offsets and reset values of the sensor control bank
// assumes a single 50 mhz clock feeding the whole block
// What this block does
// - proximity interrupts are raised only while the proximity irq enable bit is set
// - colour interrupts are raised only while the colour irq enable bit is set
// - wait enable bit turns the wait period between cycles on or off
// - proximity enable bit turns the proximity measurement on or off
// - colour enable bit turns the colour conversion on or off
// - power on bit starts or stops the oscillator for timers and converters
// - oscillator stays on during any bus transfer, whatever power on says
// - no measurement starts until 2.4 ms after power on is set
// - colour time is 256 minus setting, in 2.4 ms steps; count saturates
// - proximity time uses the same 256 minus setting step encoding
// - proximity max count is steps times 1024 minus one, capped 65535
// - wait time is two's complement of wait setting, in 2.4 ms steps
// - long wait select makes each wait step twelve times longer
// - interrupt when clear result is below low or above high threshold
// - thresholds are 16 bit, low byte first, at offsets 4 to 7
// - colour clear command drops the pending colour interrupt, self clearing
// - colour interrupt after persistence count of out of range results; 0 every cycle
// - proximity follows colour; colour time still spaces cycles if colour off
package sensor_pkg;
  localparam logic [4:0] ADDR_ENABLE    = 5'h00;
  localparam logic [4:0] ADDR_COLOUR_T  = 5'h01;
  localparam logic [4:0] ADDR_PROX_T    = 5'h02;
  localparam logic [4:0] ADDR_WAIT_T    = 5'h03;
  localparam logic [4:0] ADDR_LOW_LO    = 5'h04;
  localparam logic [4:0] ADDR_LOW_HI    = 5'h05;
  localparam logic [4:0] ADDR_HIGH_LO   = 5'h06;
  localparam logic [4:0] ADDR_HIGH_HI   = 5'h07;

  localparam int BIT_POWER_ON    = 0;
  localparam int BIT_COLOUR_EN   = 1;
  localparam int BIT_PROX_EN     = 2;
  localparam int BIT_WAIT_EN     = 3;
  localparam int BIT_COLOUR_IRQ  = 4;
  localparam int BIT_PROX_IRQ    = 5;
  localparam int ENABLE_BITS     = 6;

  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_TIME   = 8'hff;
  localparam logic [7:0] RESET_THRESH = 8'h00;

  localparam real STEP_TIME_MS  = 2.4;
  localparam real CLK_PERIOD_NS = 20.0;
  localparam int  STEP_CYCLES   =
    int'($ceil(STEP_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [3:0]  LONG_WAIT_FACTOR = 4'hc;
  localparam logic [8:0]  STEP_RANGE       = 9'h100;
  localparam logic [8:0]  WARMUP_STEPS     = 9'h001;
  localparam int          COUNT_SHIFT      = 10;
  localparam logic [18:0] MAX_COUNT        = 19'h0ffff;
  localparam logic [3:0]  PERS_LINEAR_TOP  = 4'h3;
  localparam logic [6:0]  PERS_STEP        = 7'h05;
endpackage

// ===== rtl/step_if.sv
// handshake between sequencer and step timer
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface step_if;
  logic       start;
  logic       abort;
  logic [8:0] steps;
  logic       long_mult;
  logic       done;
  modport ctrl  (output start, abort, steps, long_mult, input done);
  modport timer (input start, abort, steps, long_mult, output done);
endinterface
`default_nettype wire

// ===== rtl/step_timer.sv
// counts a number of 2.4 ms steps, optionally twelve times stretched
// assumes start is a one cycle pulse; abort wins over start
`timescale 1ns/1ps
`default_nettype none
module step_timer #(
  parameter int TICK_CYCLES = sensor_pkg::STEP_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstn,
  step_if.timer     tif
);
  logic [16:0] tick_cnt;
  logic [3:0]  mult_cnt;
  logic [8:0]  step_cnt;
  logic        busy;
  logic        long_q;
  logic        tick_end;
  logic        step_end;

  assign tick_end = tick_cnt == 17'(TICK_CYCLES - 1);
  assign step_end = tick_end &&
    (!long_q || mult_cnt == sensor_pkg::LONG_WAIT_FACTOR - 4'h1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy     <= 1'b0;
      tick_cnt <= 17'h0;
      mult_cnt <= 4'h0;
      step_cnt <= 9'h0;
      long_q   <= 1'b0;
      tif.done <= 1'b0;
    end else begin
      tif.done <= 1'b0;
      if (tif.abort) begin
        busy <= 1'b0;
      end else if (tif.start) begin
        busy     <= 1'b1;
        tick_cnt <= 17'h0;
        mult_cnt <= 4'h0;
        step_cnt <= tif.steps;
        long_q   <= tif.long_mult;
      end else if (busy) begin
        tick_cnt <= tick_end ? 17'h0 : tick_cnt + 17'h1;
        if (tick_end) begin
          mult_cnt <= step_end ? 4'h0 : mult_cnt + 4'h1;
        end
        if (step_end) begin
          if (step_cnt == 9'h001) begin
            busy     <= 1'b0;
            tif.done <= 1'b1;
          end else begin
            step_cnt <= step_cnt - 9'h001;
          end
        end
      end
    end
  end

  a_done_single: assert property (@(posedge clk) disable iff (!rstn)
    tif.done |=> !tif.done)
    else $error("step done lasted more than one cycle");
endmodule
`default_nettype wire

// ===== rtl/sensor_ctrl.sv
// enable, timing and clear threshold bank with measurement sequencer
// assumes the bus front end decodes transfers into same clock strobes,
// and the converter gives one clear_valid pulse per colour result
`timescale 1ns/1ps
`default_nettype none
module sensor_ctrl #(
  parameter int TICK_CYCLES = sensor_pkg::STEP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output var  logic [7:0]  reg_rdata,
  input  wire logic        i2c_busy,
  input  wire logic        colour_irq_clear,
  input  wire logic        prox_irq_clear,
  input  wire logic        long_wait_select,
  input  wire logic [3:0]  colour_irq_persistence,
  input  wire logic [15:0] clear_result,
  input  wire logic        clear_valid,
  input  wire logic        prox_event,
  output var  logic        osc_enable,
  output var  logic        colour_conversion,
  output var  logic        prox_active,
  output var  logic        wait_active,
  output var  logic [15:0] colour_max_count,
  output var  logic [15:0] prox_max_count,
  output var  logic        irq_n
);
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_WARMUP = 3'b001,
    S_READY  = 3'b010,
    S_COLOUR = 3'b011,
    S_PROX   = 3'b100,
    S_WAIT   = 3'b101
  } seq_state_e;

  logic [5:0]  function_enable;
  logic [7:0]  colour_integration_time;
  logic [7:0]  proximity_integration_time;
  logic [7:0]  wait_time;
  logic [7:0]  clear_low_threshold_lo;
  logic [7:0]  clear_low_threshold_hi;
  logic [7:0]  clear_high_threshold_lo;
  logic [7:0]  clear_high_threshold_hi;

  logic        power_on;
  logic        colour_function_enable;
  logic        prox_function_enable;
  logic        wait_enable;
  logic        colour_irq_enable;
  logic        prox_irq_enable;

  seq_state_e  state;
  seq_state_e  next_state;
  logic        any_measure;
  logic [6:0]  pers_count;
  logic [6:0]  pers_target;
  logic        out_of_range;
  logic        colour_set;
  logic        prox_set;
  logic        colour_pending;
  logic        prox_pending;

  step_if tif ();

  step_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk  (clk),
    .rstn (rstn),
    .tif  (tif)
  );

  // 256 minus setting; a zero setting gives the full 256 steps
  function automatic logic [8:0] steps_of(input logic [7:0] v);
    steps_of = sensor_pkg::STEP_RANGE - {1'b0, v};
  endfunction

  function automatic logic [15:0] sat16(input logic [18:0] v);
    sat16 = (v > sensor_pkg::MAX_COUNT) ? 16'hffff : v[15:0];
  endfunction

  function automatic logic [18:0] counts_of(input logic [7:0] v);
    counts_of = 19'(steps_of(v)) << sensor_pkg::COUNT_SHIFT;
  endfunction

  // persistence code 1..3 is literal, above that steps of five
  function automatic logic [6:0] pers_of(input logic [3:0] code);
    if (code <= sensor_pkg::PERS_LINEAR_TOP) begin
      pers_of = {3'h0, code};
    end else begin
      pers_of = 7'({3'h0, code} - 7'(sensor_pkg::PERS_LINEAR_TOP))
                * sensor_pkg::PERS_STEP;
    end
  endfunction

  assign power_on               = function_enable[sensor_pkg::BIT_POWER_ON];
  assign colour_function_enable = function_enable[sensor_pkg::BIT_COLOUR_EN];
  assign prox_function_enable   = function_enable[sensor_pkg::BIT_PROX_EN];
  assign wait_enable            = function_enable[sensor_pkg::BIT_WAIT_EN];
  assign colour_irq_enable      = function_enable[sensor_pkg::BIT_COLOUR_IRQ];
  assign prox_irq_enable        = function_enable[sensor_pkg::BIT_PROX_IRQ];

  // register writes; reserved enable bits are not stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      function_enable            <= sensor_pkg::RESET_ENABLE[5:0];
      colour_integration_time    <= sensor_pkg::RESET_TIME;
      proximity_integration_time <= sensor_pkg::RESET_TIME;
      wait_time                  <= sensor_pkg::RESET_TIME;
      clear_low_threshold_lo     <= sensor_pkg::RESET_THRESH;
      clear_low_threshold_hi     <= sensor_pkg::RESET_THRESH;
      clear_high_threshold_lo    <= sensor_pkg::RESET_THRESH;
      clear_high_threshold_hi    <= sensor_pkg::RESET_THRESH;
    end else if (reg_write) begin
      case (reg_addr)
        sensor_pkg::ADDR_ENABLE: begin
          // top two bits dropped whatever the host writes
          function_enable <= reg_wdata[sensor_pkg::ENABLE_BITS-1:0];
        end
        sensor_pkg::ADDR_COLOUR_T: colour_integration_time    <= reg_wdata;
        sensor_pkg::ADDR_PROX_T:   proximity_integration_time <= reg_wdata;
        sensor_pkg::ADDR_WAIT_T:   wait_time                  <= reg_wdata;
        sensor_pkg::ADDR_LOW_LO:   clear_low_threshold_lo     <= reg_wdata;
        sensor_pkg::ADDR_LOW_HI:   clear_low_threshold_hi     <= reg_wdata;
        sensor_pkg::ADDR_HIGH_LO:  clear_high_threshold_lo    <= reg_wdata;
        sensor_pkg::ADDR_HIGH_HI:  clear_high_threshold_hi    <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data held until the next read; unmapped reads give zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        sensor_pkg::ADDR_ENABLE:   reg_rdata <= {2'b00, function_enable};
        sensor_pkg::ADDR_COLOUR_T: reg_rdata <= colour_integration_time;
        sensor_pkg::ADDR_PROX_T:   reg_rdata <= proximity_integration_time;
        sensor_pkg::ADDR_WAIT_T:   reg_rdata <= wait_time;
        sensor_pkg::ADDR_LOW_LO:   reg_rdata <= clear_low_threshold_lo;
        sensor_pkg::ADDR_LOW_HI:   reg_rdata <= clear_low_threshold_hi;
        sensor_pkg::ADDR_HIGH_LO:  reg_rdata <= clear_high_threshold_lo;
        sensor_pkg::ADDR_HIGH_HI:  reg_rdata <= clear_high_threshold_hi;
        default:                   reg_rdata <= 8'h00;
      endcase
    end
  end

  // bus transfers need the oscillator even with power off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_enable <= 1'b0;
    end else begin
      osc_enable <= power_on || i2c_busy;
    end
  end

  // proximity still runs on the colour time slot, so either enable
  // starts a cycle
  assign any_measure = colour_function_enable || prox_function_enable;

  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (power_on) begin
          next_state = S_WARMUP;
        end
      end
      S_WARMUP: begin
        if (tif.done) begin
          next_state = any_measure ? S_COLOUR : S_READY;
        end
      end
      S_READY: begin
        if (any_measure) begin
          next_state = S_COLOUR;
        end
      end
      S_COLOUR: begin
        if (tif.done) begin
          if (prox_function_enable) begin
            next_state = S_PROX;
          end else if (wait_enable) begin
            next_state = S_WAIT;
          end else if (!any_measure) begin
            next_state = S_READY;
          end
        end
      end
      S_PROX: begin
        if (tif.done) begin
          if (wait_enable) begin
            next_state = S_WAIT;
          end else begin
            next_state = any_measure ? S_COLOUR : S_READY;
          end
        end
      end
      S_WAIT: begin
        if (tif.done) begin
          next_state = any_measure ? S_COLOUR : S_READY;
        end
      end
      default: next_state = S_IDLE;
    endcase
    if (!power_on) begin
      next_state = S_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // launch the timer on entry, or again when a state repeats
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tif.start     <= 1'b0;
      tif.abort     <= 1'b0;
      tif.steps     <= sensor_pkg::WARMUP_STEPS;
      tif.long_mult <= 1'b0;
    end else begin
      tif.abort     <= next_state == S_IDLE;
      tif.start     <= (next_state != S_IDLE) && (next_state != S_READY) &&
                       ((next_state != state) || tif.done);
      tif.long_mult <= (next_state == S_WAIT) && long_wait_select;
      case (next_state)
        S_COLOUR: tif.steps <= steps_of(colour_integration_time);
        S_PROX:   tif.steps <= steps_of(proximity_integration_time);
        S_WAIT:   tif.steps <= steps_of(wait_time);
        default:  tif.steps <= sensor_pkg::WARMUP_STEPS;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      colour_conversion <= 1'b0;
      prox_active       <= 1'b0;
      wait_active       <= 1'b0;
    end else begin
      // colour slot without colour enable only times the interval
      colour_conversion <= (state == S_COLOUR) &&
                           colour_function_enable;
      prox_active       <= state == S_PROX;
      wait_active       <= state == S_WAIT;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      colour_max_count <= 16'h0000;
      prox_max_count   <= 16'h0000;
    end else begin
      colour_max_count <= sat16(counts_of(colour_integration_time));
      prox_max_count   <=
        sat16(counts_of(proximity_integration_time) - 19'h1);
    end
  end

  assign out_of_range =
    (clear_result < {clear_low_threshold_hi, clear_low_threshold_lo}) ||
    (clear_result > {clear_high_threshold_hi, clear_high_threshold_lo});
  assign pers_target = pers_of(colour_irq_persistence);

  // results only count while colour conversion is enabled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pers_count <= 7'h00;
    end else if (clear_valid && colour_function_enable) begin
      if (!out_of_range) begin
        pers_count <= 7'h00;
      end else if (pers_count != 7'h7f) begin
        pers_count <= pers_count + 7'h01;
      end
    end
  end

  // no increment here: a saturated count would wrap to zero
  assign colour_set = clear_valid && colour_function_enable &&
    colour_irq_enable &&
    ((pers_target == 7'h00) ||
     (out_of_range && (pers_count >= pers_target - 7'h01)));
  assign prox_set = prox_event && prox_irq_enable;

  // a new event in the clearing cycle keeps the flag set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      colour_pending <= 1'b0;
      prox_pending   <= 1'b0;
    end else begin
      if (colour_set) begin
        colour_pending <= 1'b1;
      end else if (colour_irq_clear) begin
        colour_pending <= 1'b0;
      end
      if (prox_set) begin
        prox_pending <= 1'b1;
      end else if (prox_irq_clear) begin
        prox_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(colour_pending || prox_pending);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_osc_bus_hold: assert property (
    i2c_busy |=> osc_enable)
    else $error("oscillator off during bus transfer");
  a_osc_power_off: assert property (
    (!power_on && !i2c_busy) |=> !osc_enable)
    else $error("oscillator on with power off and bus idle");
  a_warmup_first: assert property (
    (state == S_IDLE && power_on) |=> state == S_WARMUP ##1
    (state == S_WARMUP || !power_on) [*2])
    else $error("measurement started without warm up");
  a_idle_power_off: assert property (
    !power_on |=> state == S_IDLE && !tif.start)
    else $error("sequencer active with power off");
  a_prox_gate: assert property (
    $rose(prox_pending) |-> $past(prox_irq_enable))
    else $error("proximity interrupt without enable");
  a_colour_gate: assert property (
    $rose(colour_pending) |-> $past(colour_irq_enable) &&
    $past(clear_valid))
    else $error("colour interrupt without enable");
  a_wait_entry: assert property (
    (state != S_WAIT && next_state == S_WAIT) |-> wait_enable)
    else $error("wait entered while disabled");
  a_prox_entry: assert property (
    (state != S_PROX && next_state == S_PROX) |->
    prox_function_enable && state == S_COLOUR)
    else $error("proximity not after colour slot");
  a_colour_single: assert property (
    colour_integration_time == 8'hff |=> colour_max_count == 16'h0400)
    else $error("colour max count wrong for one step");
  a_prox_single: assert property (
    proximity_integration_time == 8'hff |=> prox_max_count == 16'h03ff)
    else $error("proximity max count wrong for one step");
  a_colour_clear: assert property (
    (colour_irq_clear && !colour_set && !prox_pending && !prox_set)
    |=> !colour_pending ##1 irq_n)
    else $error("colour interrupt not dropped by clear");

  c_colour_to_prox: cover property (
    state == S_COLOUR && next_state == S_PROX);
  c_wait_entered: cover property (state == S_PROX ##1 state == S_WAIT);
  c_irq_raised: cover property ($fell(irq_n));
  c_warmup_done: cover property (state == S_WARMUP ##1 state == S_COLOUR);
endmodule
`default_nettype wire

// ===== verification/host_model.sv
// host side of the register strobes, one access at a time
// assumes the bench calls its tasks; drives follow rising clk edges
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  output var  logic [4:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_write,
  output var  logic       reg_read,
  output var  logic       i2c_busy
);
  initial begin
    reg_addr = 5'h1f;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    i2c_busy = 1'b0;
  end

  // busy frames the strobe, as a real bus transfer would
  task automatic access(input logic [4:0] a, input logic [7:0] d,
                        input logic wr);
    @(posedge clk);
    i2c_busy <= 1'b1;
    reg_addr <= a;
    reg_wdata <= (a == 5'h00) ? (d & 8'h3f) : d;
    reg_write <= wr;
    reg_read <= !wr;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    // released lines must not look like the last value
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge clk);
    i2c_busy <= 1'b0;
  endtask

  task automatic hold_busy(input int n);
    @(posedge clk);
    i2c_busy <= 1'b1;
    repeat (n) @(posedge clk);
    i2c_busy <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the sensor control bank
// assumes sensor_ctrl with a 4 cycle step and host_model as bus side
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int T = 4;
  logic        clk, rstn, colour_irq_clear, prox_irq_clear;
  logic        long_wait_select, clear_valid, prox_event;
  logic [3:0]  colour_irq_persistence;
  logic [15:0] clear_result, colour_max_count, prox_max_count;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        reg_write, reg_read, i2c_busy, osc_enable, irq_n;
  logic        colour_conversion, prox_active, wait_active;
  wire  logic [2:0] act;
  logic        rd_seen = 1'b0;
  logic [7:0]  exp_q[$];
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          seed = 32'hdc697e2d;
  logic [7:0]  tv[5] = '{8'hff, 8'hf6, 8'hd6, 8'had, 8'h00};
  logic [15:0] cm[5] = '{16'h0400, 16'h2800, 16'ha800, 16'hffff, 16'hffff};
  logic [7:0]  pv[5] = '{8'hff, 8'hfe, 8'hc1, 8'h01, 8'h00};
  logic [15:0] pm[5] = '{16'h03ff, 16'h07ff, 16'hfbff, 16'hffff, 16'hffff};

  assign act = {wait_active, prox_active, colour_conversion};

  host_model host_u (.clk, .reg_addr, .reg_wdata, .reg_write, .reg_read,
                     .i2c_busy);
  sensor_ctrl #(.TICK_CYCLES(T)) dut_u (.clk, .rstn, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .i2c_busy,
    .colour_irq_clear, .prox_irq_clear, .long_wait_select,
    .colour_irq_persistence, .clear_result, .clear_valid, .prox_event,
    .osc_enable, .colour_conversion, .prox_active, .wait_active,
    .colour_max_count, .prox_max_count, .irq_n);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang;
    n_mismatch++;
    final_report();
  endtask

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  // read data is answered one edge after the strobe edge
  always @(posedge clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) hang();
      else check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
    rd_seen <= reg_read;
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host_u.access(a, d, 1'b1);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.access(a, 8'h00, 1'b0);
  endtask

  // lead = cycles until the slot opens; slot length checked with slack
  task automatic slot(input int i, input int s, input string nm,
                      output int lead);
    int n = 0;
    while (act[i] !== 1'b1) begin
      if (n == 400) hang();
      tick();
      n++;
    end
    lead = n;
    n = 0;
    while (act[i] === 1'b1) begin
      if (n == 3000) hang();
      tick();
      n++;
    end
    check(nm, 16'(n >= s * T && n <= s * T + 3), 16'h0001);
  endtask

  // k: 0 colour result, 1 prox event, 2 colour clear, 3 prox clear
  task automatic hit(input int k, input logic [15:0] r, input logic e);
    @(posedge clk);
    clear_result <= r;
    clear_valid <= (k == 0);
    prox_event <= (k == 1);
    colour_irq_clear <= (k == 2);
    prox_irq_clear <= (k == 3);
    @(posedge clk);
    {clear_valid, prox_event, colour_irq_clear, prox_irq_clear} <= 4'h0;
    clear_result <= ~r;
    repeat (3) tick();
    check("irq_n", irq_n, e);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    hang();
  end

  initial begin
    logic [7:0] d;
    int n;
    rstn = 1'b0;
    {colour_irq_clear, prox_irq_clear, long_wait_select} = 3'h0;
    {clear_valid, prox_event} = 2'h0;
    colour_irq_persistence = 4'h1;
    clear_result = 16'h0000;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) tick();
    check("colour_max_count", colour_max_count, 16'h0400);
    check("prox_max_count", prox_max_count, 16'h03ff);
    check("osc_enable", osc_enable, 16'h0000);
    for (int a = 0; a < 9; a++) begin
      d = (a == 0) ? sensor_pkg::RESET_ENABLE : (a < 4) ?
          sensor_pkg::RESET_TIME : (a < 8) ? sensor_pkg::RESET_THRESH : 8'h00;
      rd(5'(a), d);
    end
    for (int a = 4; a < 8; a++) begin
      d = 8'($random(seed));
      wr(5'(a), d);
      rd(5'(a), d);
    end
    for (int k = 0; k < 5; k++) begin
      wr(5'h01, tv[k]);
      wr(5'h02, pv[k]);
      tick();
      check("colour_max_count", colour_max_count, cm[k]);
      check("prox_max_count", prox_max_count, pm[k]);
    end
    fork
      host_u.hold_busy(6);
      begin
        repeat (4) tick();
        check("osc_enable busy", osc_enable, 16'h0001);
      end
    join
    repeat (4) tick();
    check("osc_enable off", osc_enable, 16'h0000);
    wr(5'h01, 8'hfe);
    wr(5'h02, 8'hff); // single step as recommended
    wr(5'h03, 8'hfe);
    wr(5'h00, 8'h0f);
    slot(0, 2, "colour slot", n);
    check("warm up", 16'(n >= T - 1), 16'h0001);
    check("osc_enable on", osc_enable, 16'h0001);
    @(posedge clk) long_wait_select <= 1'b1;
    slot(1, 1, "prox slot", n);
    slot(2, 24, "long wait", n);
    @(posedge clk) long_wait_select <= 1'b0;
    slot(0, 2, "colour slot", n);
    slot(1, 1, "prox slot", n);
    slot(2, 2, "wait slot", n);
    rd(5'h00, 8'h0f);
    wr(5'h00, 8'h07);
    slot(1, 1, "prox slot", n);
    slot(0, 2, "colour slot", n);
    check("no wait", 16'(n <= 3), 16'h0001);
    wr(5'h00, 8'h05);
    // the slot running at the write is partial; measure the next one
    n = 0;
    while (act[1] === 1'b1) begin
      if (n == 400) hang();
      tick();
      n++;
    end
    slot(1, 1, "prox slot", n);
    slot(1, 1, "prox slot", n);
    check("prox spacing", 16'(n >= 2*T && n <= 2*T + 4), 16'h0001);
    check("colour off", colour_conversion, 16'h0000);
    wr(5'h00, 8'h00);
    repeat (4) tick();
    check("idle", {osc_enable, act}, 16'h0000);
    wr(5'h04, 8'h00);
    wr(5'h05, 8'h01);
    wr(5'h06, 8'h00);
    wr(5'h07, 8'h02);
    wr(5'h00, 8'h13);
    hit(0, 16'h0100 + 16'($unsigned($random(seed)) % 257), 1'b1);
    hit(0, 16'h0100, 1'b1);
    hit(0, 16'h0200, 1'b1);
    hit(0, 16'h0201, 1'b0);
    hit(2, 16'h0000, 1'b1);
    hit(0, 16'h00ff, 1'b0);
    hit(2, 16'h0000, 1'b1);
    @(posedge clk) colour_irq_persistence <= 4'h2;
    hit(0, 16'h0150, 1'b1);
    hit(0, 16'h0000, 1'b1);
    hit(0, 16'h0000, 1'b0);
    hit(2, 16'h0000, 1'b1);
    @(posedge clk) colour_irq_persistence <= 4'h0;
    hit(0, 16'h0150, 1'b0);
    hit(2, 16'h0000, 1'b1);
    @(posedge clk) colour_irq_persistence <= 4'h4;
    for (int k = 0; k < 5; k++) begin
      hit(0, 16'h0000, 1'(k < 4));
    end
    hit(2, 16'h0000, 1'b1);
    wr(5'h00, 8'h03);
    hit(0, 16'h0000, 1'b1);
    hit(0, 16'hffff, 1'b1);
    wr(5'h00, 8'h23);
    hit(1, 16'h0150, 1'b0);
    hit(3, 16'h0150, 1'b1);
    wr(5'h00, 8'h03);
    hit(1, 16'h0150, 1'b1);
    repeat (4) tick();
    final_report();
  end
endmodule
`default_nettype wire
